// [port_status_params.svh]
// Offsets, field positions, reset values and widths of the status group.
// Assumes it is included by bare name from the files that need it.
`ifndef PORT_STATUS_PARAMS_SVH
`define PORT_STATUS_PARAMS_SVH

`define PS_ADDR_W            8
`define PS_DATA_W            16
`define PS_PORTS             12
`define PS_TEMP_W            12
`define PS_AVG_W             3
`define PS_CNT_W             7

`define PS_OFS_CONV_LOW      8'h00
`define PS_OFS_CONV_HIGH     8'h01
`define PS_OFS_ONCHIP_TEMP   8'h02
`define PS_OFS_REMOTE1_TEMP  8'h03
`define PS_OFS_REMOTE2_TEMP  8'h04
`define PS_OFS_EVENT_LOW     8'h05
`define PS_OFS_EVENT_HIGH    8'h06

`define PS_LOW_A_LSB         2
`define PS_LOW_A_MSB         7
`define PS_LOW_B_LSB         11
`define PS_LOW_B_MSB         15
`define PS_LOW_A_PORTS       6
`define PS_HIGH_BIT          0

`define PS_MODE_NONE         2'h0
`define PS_MODE_RISE         2'h1
`define PS_MODE_FALL         2'h2
`define PS_MODE_BOTH         2'h3

`define PS_STATUS_RST        12'h000
`define PS_TEMP_RST          12'h000
`define PS_CNT_RST           7'h00
`define PS_DATA_RST          16'h0000

`endif

// [port_status_pkg.sv]
// Types shared by the status group.
// Assumes port_status_params.svh is on the include path.
`default_nettype none
package port_status_pkg;
  typedef enum logic [3:0] {
    SEQ_IDLE  = 4'b0001,
    SEQ_ARMED = 4'b0010,
    SEQ_LOW   = 4'b0100,
    SEQ_HIGH  = 4'b1000
  } clear_seq_e;
endpackage : port_status_pkg
`default_nettype wire

// [input_event_detect.sv]
// Per-port edge detector for general-purpose input pins.
// Assumes pins are asynchronous to ref_clk_in; they are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "port_status_params.svh"
module input_event_detect #(
  parameter int PORTS = 12
) (
  input  wire logic               ref_clk_in,
  input  wire logic               rst_b_in,
  input  wire logic [PORTS-1:0]   pin_in,
  input  wire logic [PORTS-1:0]   input_port_enable_in,
  input  wire logic [2*PORTS-1:0] edge_mode_in,
  output logic      [PORTS-1:0]   event_out
);
  logic [PORTS-1:0] sync1_reg;
  logic [PORTS-1:0] sync2_reg;
  logic [PORTS-1:0] prev_reg;
  logic [PORTS-1:0] prev_next;
  logic [1:0]       fill_reg;
  logic [1:0]       fill_next;
  logic             primed;

  // No edges until prev_reg holds a synchronised level, so a pin
  // already high at reset release is not taken for a rising edge
  always_comb begin
    prev_next = sync2_reg;
    fill_next = primed ? fill_reg : fill_reg + 2'h1;
  end

  assign primed = fill_reg == 2'h3;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg  <= '0;
      fill_reg  <= '0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      prev_reg  <= prev_next;
      fill_reg  <= fill_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  genvar i;
  generate
    for (i = 0; i < PORTS; i++) begin : g_port
      logic en;
      logic rise;
      logic fall;
      assign en   = input_port_enable_in[i];
      assign rise = primed & sync2_reg[i] & ~prev_reg[i];
      assign fall = primed & ~sync2_reg[i] & prev_reg[i];
      always_comb begin
        case (edge_mode_in[2*i +: 2])
          `PS_MODE_RISE: event_out[i] = en & rise;
          `PS_MODE_FALL: event_out[i] = en & fall;
          `PS_MODE_BOTH: event_out[i] = en & (rise | fall);
          default:       event_out[i] = 1'b0;
        endcase
      end
    end
  endgenerate
endmodule : input_event_detect
`default_nettype wire

// [port_status_regs.sv]
// Status and temperature readout registers of the port expander.
// Assumes reads come from the serial interface as one-cycle strobes on
// ref_clk_in, and the interrupt register read is signalled by the core.
//
// Summary of operation
// - Result write sets that port's converter status
// - Averaging ports update after full sample set
// - Converter status ignores every interrupt mask
// - Clear needs interrupt read, then both reads
// - Ports 0-5 bits 7:2, 6-10 bits 15:11
// - Temperatures are 12-bit two's complement, bits 11:0
// - On-chip sensor has its own register
// - First remote sensor has own register
// - Second remote sensor has own register
// - Enabled input port edge sets event status
// - Event status ignores every interrupt mask
// - Event clear needs interrupt read, both reads
// - Event bits use same split layout
// - Edge mode selects none, rise, fall or both
// - Data-ready interrupt bit on any new result
// - Event interrupt bit on any new event
`timescale 1ns/1ps
`default_nettype none
`include "port_status_params.svh"
module port_status_regs
  import port_status_pkg::*;
#(
  parameter int PORTS = `PS_PORTS
) (
  input  wire logic                    ref_clk_in,
  input  wire logic                    rst_b_in,
  input  wire logic                    rd_en_in,
  input  wire logic [`PS_ADDR_W-1:0]   rd_addr_in,
  output logic      [`PS_DATA_W-1:0]   rd_data_out,
  input  wire logic                    irq_reg_read_in,
  input  wire logic [PORTS-1:0]        conv_sample_in,
  input  wire logic [PORTS*3-1:0]      avg_log2_in,
  input  wire logic [PORTS-1:0]        general_purpose_input_in,
  input  wire logic [PORTS-1:0]        input_port_enable_in,
  input  wire logic [2*PORTS-1:0]      input_edge_mode_in,
  input  wire logic                    onchip_temp_valid_in,
  input  wire logic [`PS_TEMP_W-1:0]   onchip_temp_in,
  input  wire logic                    remote1_temp_valid_in,
  input  wire logic [`PS_TEMP_W-1:0]   remote1_temp_in,
  input  wire logic                    remote2_temp_valid_in,
  input  wire logic [`PS_TEMP_W-1:0]   remote2_temp_in,
  output logic      [PORTS-1:0]        conv_result_write_out,
  output logic                         conv_data_ready_irq_out,
  output logic                         input_event_ready_irq_out
);
  if (PORTS != `PS_PORTS) begin : g_bad_ports
    $error("Register layout serves twelve ports");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Averaging counters: result written only after 2^N samples
  logic [`PS_CNT_W-1:0] cnt_reg  [PORTS];
  logic [`PS_CNT_W-1:0] cnt_next [PORTS];
  logic [PORTS-1:0]     conv_write;

  genvar p;
  generate
    for (p = 0; p < PORTS; p++) begin : g_avg
      logic [`PS_CNT_W-1:0] last;
      assign last = `PS_CNT_W'((8'h01 << avg_log2_in[3*p +: 3]) - 8'h01);
      always_comb begin
        cnt_next[p]   = cnt_reg[p];
        conv_write[p] = 1'b0;
        if (conv_sample_in[p]) begin
          if (cnt_reg[p] >= last) begin
            cnt_next[p]   = `PS_CNT_RST;
            conv_write[p] = 1'b1;
          end else begin
            cnt_next[p] = cnt_reg[p] + `PS_CNT_W'(1);
          end
        end
      end
      always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          cnt_reg[p] <= `PS_CNT_RST;
        end else begin
          cnt_reg[p] <= cnt_next[p];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  logic [PORTS-1:0] input_event;

  input_event_detect #(
    .PORTS (PORTS)
  ) u_detect (
    .ref_clk_in           (ref_clk_in),
    .rst_b_in             (rst_b_in),
    .pin_in               (general_purpose_input_in),
    .input_port_enable_in (input_port_enable_in),
    .edge_mode_in         (input_edge_mode_in),
    .event_out            (input_event)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clear sequencing: group 0 converter, group 1 input events
  logic [1:0]             rd_low;
  logic [1:0]             rd_high;
  logic [1:0]             clr;
  logic [PORTS-1:0]       set_bits [2];
  clear_seq_e             seq_reg  [2];
  clear_seq_e             seq_next [2];
  logic [PORTS-1:0]       status_reg  [2];
  logic [PORTS-1:0]       status_next [2];
  logic [1:0]             pend_reg;
  logic [1:0]             pend_next;

  assign set_bits[0] = conv_write;
  assign set_bits[1] = input_event;
  assign rd_low[0]   = rd_en_in && rd_addr_in == `PS_OFS_CONV_LOW;
  assign rd_high[0]  = rd_en_in && rd_addr_in == `PS_OFS_CONV_HIGH;
  assign rd_low[1]   = rd_en_in && rd_addr_in == `PS_OFS_EVENT_LOW;
  assign rd_high[1]  = rd_en_in && rd_addr_in == `PS_OFS_EVENT_HIGH;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_grp
      always_comb begin
        seq_next[g] = seq_reg[g];
        clr[g]      = 1'b0;
        case (seq_reg[g])
          SEQ_IDLE: begin
            seq_next[g] = SEQ_IDLE;
          end
          SEQ_ARMED: begin
            if (rd_low[g]) begin
              seq_next[g] = SEQ_LOW;
            end else if (rd_high[g]) begin
              seq_next[g] = SEQ_HIGH;
            end
          end
          SEQ_LOW: begin
            if (rd_high[g]) begin
              clr[g]      = 1'b1;
              seq_next[g] = SEQ_IDLE;
            end
          end
          SEQ_HIGH: begin
            if (rd_low[g]) begin
              clr[g]      = 1'b1;
              seq_next[g] = SEQ_IDLE;
            end
          end
          default: begin
            seq_next[g] = SEQ_IDLE;
          end
        endcase
        // Interrupt read always restarts the sequence
        if (irq_reg_read_in) begin
          seq_next[g] = SEQ_ARMED;
        end
        // Set after clear so a same-cycle event survives
        status_next[g] = (clr[g] ? `PS_STATUS_RST : status_reg[g])
                         | set_bits[g];
        pend_next[g]   = (clr[g] ? 1'b0 : pend_reg[g])
                         | (|set_bits[g]);
      end
      always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          seq_reg[g]    <= SEQ_IDLE;
          status_reg[g] <= `PS_STATUS_RST;
          pend_reg[g]   <= 1'b0;
        end else begin
          seq_reg[g]    <= seq_next[g];
          status_reg[g] <= status_next[g];
          pend_reg[g]   <= pend_next[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Temperature holding registers, reserved upper bits read zero
  logic [`PS_TEMP_W-1:0] onchip_reg;
  logic [`PS_TEMP_W-1:0] onchip_next;
  logic [`PS_TEMP_W-1:0] remote1_reg;
  logic [`PS_TEMP_W-1:0] remote1_next;
  logic [`PS_TEMP_W-1:0] remote2_reg;
  logic [`PS_TEMP_W-1:0] remote2_next;

  always_comb begin
    onchip_next  = onchip_temp_valid_in  ? onchip_temp_in  : onchip_reg;
    remote1_next = remote1_temp_valid_in ? remote1_temp_in : remote1_reg;
    remote2_next = remote2_temp_valid_in ? remote2_temp_in : remote2_reg;
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      onchip_reg  <= `PS_TEMP_RST;
      remote1_reg <= `PS_TEMP_RST;
      remote2_reg <= `PS_TEMP_RST;
    end else begin
      onchip_reg  <= onchip_next;
      remote1_reg <= remote1_next;
      remote2_reg <= remote2_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data registered; value sampled before any clear it causes
  function automatic logic [`PS_DATA_W-1:0] low_word(
    input logic [PORTS-1:0] s
  );
    logic [`PS_DATA_W-1:0] w;
    w = `PS_DATA_RST;
    w[`PS_LOW_A_MSB:`PS_LOW_A_LSB] = s[`PS_LOW_A_PORTS-1:0];
    w[`PS_LOW_B_MSB:`PS_LOW_B_LSB] = s[PORTS-2:`PS_LOW_A_PORTS];
    return w;
  endfunction : low_word

  logic [`PS_DATA_W-1:0] rd_data_reg;
  logic [`PS_DATA_W-1:0] rd_data_next;
  logic [`PS_DATA_W-1:0] high_word [2];

  always_comb begin
    high_word[0] = `PS_DATA_RST;
    high_word[1] = `PS_DATA_RST;
    high_word[0][`PS_HIGH_BIT] = status_reg[0][PORTS-1];
    high_word[1][`PS_HIGH_BIT] = status_reg[1][PORTS-1];
    rd_data_next = rd_data_reg;
    if (rd_en_in) begin
      case (rd_addr_in)
        `PS_OFS_CONV_LOW:     rd_data_next = low_word(status_reg[0]);
        `PS_OFS_CONV_HIGH:    rd_data_next = high_word[0];
        `PS_OFS_ONCHIP_TEMP:  rd_data_next = {4'h0, onchip_reg};
        `PS_OFS_REMOTE1_TEMP: rd_data_next = {4'h0, remote1_reg};
        `PS_OFS_REMOTE2_TEMP: rd_data_next = {4'h0, remote2_reg};
        `PS_OFS_EVENT_LOW:    rd_data_next = low_word(status_reg[1]);
        `PS_OFS_EVENT_HIGH:   rd_data_next = high_word[1];
        default:              rd_data_next = `PS_DATA_RST;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_data_reg <= `PS_DATA_RST;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data_out               = rd_data_reg;
  assign conv_result_write_out     = conv_write;
  assign conv_data_ready_irq_out   = pend_reg[0];
  assign input_event_ready_irq_out = pend_reg[1];
endmodule : port_status_regs
`default_nettype wire

// [port_status_asserts.sv]
// Concurrent checks on the status readout group's ports.
// Assumes it is bound to port_status_regs with PORTS of 12.
`timescale 1ns/1ps
`default_nettype none
module port_status_asserts #(
  parameter int PORTS = 12
) (
  input wire logic             ref_clk_in,
  input wire logic             rst_b_in,
  input wire logic             rd_en_in,
  input wire logic [7:0]       rd_addr_in,
  input wire logic [15:0]      rd_data_out,
  input wire logic [PORTS-1:0] conv_sample_in,
  input wire logic [PORTS*3-1:0] avg_log2_in,
  input wire logic [PORTS-1:0] conv_result_write_out,
  input wire logic             conv_data_ready_irq_out,
  input wire logic             input_event_ready_irq_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////////////////////////
  a_unmapped_zero: assert property (rd_en_in && rd_addr_in > 8'h06
    |=> rd_data_out == 16'h0000) else $error("unmapped read not zero");
  a_data_holds: assert property (!rd_en_in |=> $stable(rd_data_out))
    else $error("read data moved without a read");
  a_write_cause: assert property (
    (conv_result_write_out & ~conv_sample_in) == 12'h000)
    else $error("result write without a sample");
  a_direct_write: assert property (
    conv_sample_in[0] && avg_log2_in[2:0] == 3'h0
    |-> conv_result_write_out[0]) else $error("unaveraged write missing");
  a_ready_sets: assert property (|conv_result_write_out
    |=> conv_data_ready_irq_out) else $error("data ready not set");
  a_ready_cause: assert property ($rose(conv_data_ready_irq_out)
    |-> $past(|conv_result_write_out)) else $error("data ready uncaused");
  a_ready_holds: assert property (conv_data_ready_irq_out && !rd_en_in
    |=> conv_data_ready_irq_out) else $error("data ready lost");
  a_event_holds: assert property (input_event_ready_irq_out && !rd_en_in
    |=> input_event_ready_irq_out) else $error("event lost");
endmodule : port_status_asserts
bind port_status_regs port_status_asserts #(.PORTS(PORTS)) i_chk (
  .ref_clk_in, .rst_b_in, .rd_en_in, .rd_addr_in, .rd_data_out,
  .conv_sample_in, .avg_log2_in, .conv_result_write_out,
  .conv_data_ready_irq_out, .input_event_ready_irq_out);
`default_nettype wire

// [tb.sv]
// Self-checking bench for the status readout group.
// Assumes 20 MHz clock; bench acts as serial interface and core.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        rd_en = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic        irq_rd = 1'b0;
  logic [11:0] samp = 12'h000;
  logic [35:0] avg = 36'h2;
  logic [11:0] pin = 12'h000;
  logic [11:0] gen = 12'h000;
  logic [23:0] mode = 24'h0;
  logic [2:0]  tv = 3'h0;
  logic [11:0] t0 = 12'h000;
  logic [11:0] t1 = 12'h000;
  logic [11:0] t2 = 12'h000;
  logic [15:0] rdata;
  logic        rdy;
  logic        evr;
  logic [11:0] wr;
  int          error_cnt = 0;
  int          n_compared = 0;
  always #25 clk = ~clk;
  port_status_regs #(.PORTS(12)) i_port_status_regs (
    .ref_clk_in(clk), .rst_b_in(rst_b), .rd_en_in(rd_en),
    .rd_addr_in(addr), .rd_data_out(rdata), .irq_reg_read_in(irq_rd),
    .conv_sample_in(samp), .avg_log2_in(avg),
    .general_purpose_input_in(pin),
    .input_port_enable_in(gen), .input_edge_mode_in(mode),
    .onchip_temp_valid_in(tv[0]), .onchip_temp_in(t0),
    .remote1_temp_valid_in(tv[1]), .remote1_temp_in(t1),
    .remote2_temp_valid_in(tv[2]), .remote2_temp_in(t2),
    .conv_result_write_out(wr), .conv_data_ready_irq_out(rdy),
    .input_event_ready_irq_out(evr));
  ////////////////////////////////////////////////////////////
  task automatic tick;
    @(posedge clk);
    #5;
  endtask : tick
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Leading idle cycle keeps rd_en from two writes in one step
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    tick;
    rd_en = 1'b1;
    addr = a;
    tick;
    rd_en = 1'b0;
    chk("rd_data_out", e, rdata);
  endtask : rd
  // Write pulse is combinational, looked at once samp has settled
  task automatic conv(input logic [11:0] m, input logic [11:0] e);
    samp = m;
    #1;
    chk("conv_result_write_out", {4'h0, e}, {4'h0, wr});
    tick;
    samp = 12'h000;
    tick;
  endtask : conv
  task automatic irq_read;
    irq_rd = 1'b1;
    tick;
    irq_rd = 1'b0;
  endtask : irq_read
  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    for (int a = 0; a < 8; a++) rd(8'(a), 16'h0000);
  endtask : t_reset
  task automatic t_temps;
    t0 = 12'h801;
    t1 = 12'h7ff;
    t2 = 12'h123;
    tv = 3'h7;
    tick;
    tv = 3'h0;
    rd(8'h02, 16'h0801);
    rd(8'h03, 16'h07ff);
    rd(8'h04, 16'h0123);
    rd(8'h08, 16'h0000);
  endtask : t_temps
  task automatic t_conv;
    repeat (3) conv(12'h001, 12'h000);
    rd(8'h00, 16'h0000);
    conv(12'hc41, 12'hc41);
    chk("conv_data_ready_irq_out", 16'h1, {15'h0, rdy});
    rd(8'h00, 16'h8804);
    rd(8'h01, 16'h0001);
  endtask : t_conv
  task automatic t_clear;
    irq_read;
    rd(8'h00, 16'h8804);
    rd(8'h00, 16'h8804);
    samp = 12'h800;
    rd(8'h01, 16'h0001);
    samp = 12'h000;
    rd(8'h00, 16'h0000);
    rd(8'h01, 16'h0001);
    chk("conv_data_ready_irq_out", 16'h1, {15'h0, rdy});
    // A second interrupt read restarts the pair, then high-first order
    irq_read;
    rd(8'h00, 16'h0000);
    irq_read;
    rd(8'h01, 16'h0001);
    rd(8'h01, 16'h0001);
    chk("conv_data_ready_irq_out", 16'h1, {15'h0, rdy});
    rd(8'h00, 16'h0000);
    rd(8'h01, 16'h0000);
    chk("conv_data_ready_irq_out", 16'h0, {15'h0, rdy});
  endtask : t_clear
  // Port 3 enabled with no mode, port 4 moded but not enabled
  task automatic t_events;
    gen = 12'h80f;
    mode = 24'h400339;
    tick;
    pin = 12'h81f;
    repeat (6) tick;
    chk("input_event_ready_irq_out", 16'h1, {15'h0, evr});
    irq_read;
    rd(8'h05, 16'h0014);
    rd(8'h06, 16'h0001);
    rd(8'h05, 16'h0000);
    chk("input_event_ready_irq_out", 16'h0, {15'h0, evr});
    pin = 12'h000;
    repeat (6) tick;
    rd(8'h05, 16'h0018);
    rd(8'h06, 16'h0000);
    irq_read;
    rd(8'h06, 16'h0000);
    rd(8'h05, 16'h0018);
    rd(8'h05, 16'h0000);
    chk("input_event_ready_irq_out", 16'h0, {15'h0, evr});
  endtask : t_events
  // Reset mid-run with port 0 pin high: flags clear, no false edge
  task automatic t_midreset;
    conv(12'h800, 12'h800);
    rst_b = 1'b0;
    pin = 12'h001;
    tick;
    rst_b = 1'b1;
    repeat (6) tick;
    chk("input_event_ready_irq_out", 16'h0, {15'h0, evr});
    chk("conv_data_ready_irq_out", 16'h0, {15'h0, rdy});
    rd(8'h05, 16'h0000);
    rd(8'h01, 16'h0000);
    rd(8'h02, 16'h0000);
  endtask : t_midreset
  ////////////////////////////////////////////////////////////
  task automatic summarize;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (6) @(posedge clk);
    #5;
    rst_b = 1'b1;
    t_reset;
    t_temps;
    t_conv;
    t_clear;
    t_events;
    t_midreset;
    summarize;
  end
  // Hang guard, far beyond the roughly 120 cycles used
  initial begin
    #1000000;
    error_cnt++;
    summarize;
  end
endmodule : tb
`default_nettype wire
